// *** logic/dw_watchpoint.sv ***
// Data address and value watchpoint for the load/store pipeline.
// Operation
// - Inclusive range: load in [cmp1, cmp2) sets enabled read flags.
// - Exclusive: outside [cmp1, cmp2) qualifies; stores set write flags.
// - Status flags are sticky; misses never clear them.
// - Block invalidate, block zero and allocate count as stores.
// - Block flush and block store raise write events only.
// - Touch, store-touch, icache touch, icache invalidate count as loads.
// - Whole-cache invalidates and cache array reads raise no events.
// - Value event needs an address match then a data match.
// - Value compare enabled suppresses that channel's address events.
// - Value event after completion; return address is next instruction.
// - Value channel enabled exactly when its byte enables are non-zero.
// - Byte enable n includes byte n in the compare.
// - Mode 01 needs every enabled byte equal.
// - Mode 10 needs at least one enabled byte equal.
// - Mode 11 matches on enabled equal bytes 0,1 or bytes 2,3.
// - Misaligned first part event recorded; value event interrupt abandons second part.
// - Value events set read or write flag per access and enables.
// - Failed value check leaves flags unchanged despite address match.
// - Range enable selects range mode, disabling exact compare.
// - Exact size field masks none, bit 31, 30:31 or 27:31.
module dw_watchpoint (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      access_valid,
  input  wire dw_pkg::dw_op_t            access_op,
  input  wire logic [dw_pkg::ADDR_W-1:0] access_addr,
  input  wire logic [dw_pkg::DATA_W-1:0] access_data,
  input  wire logic                      access_first_part,
  input  wire logic [dw_pkg::ADDR_W-1:0] access_instr_addr,
  input  wire logic [dw_pkg::ADDR_W-1:0] access_next_addr,
  input  wire logic                      debug_int_enable,
  input  wire logic [dw_pkg::ADDR_W-1:0] data_addr_compare_one,
  input  wire logic [dw_pkg::ADDR_W-1:0] data_addr_compare_two,
  input  wire logic [dw_pkg::DATA_W-1:0] data_value_compare_one,
  input  wire logic [dw_pkg::DATA_W-1:0] data_value_compare_two,
  input  wire logic                      range_compare_enable,
  input  wire logic                      range_exclusive_select,
  input  wire logic                      read_watch_enable_one,
  input  wire logic                      write_watch_enable_one,
  input  wire logic                      read_watch_enable_two,
  input  wire logic                      write_watch_enable_two,
  input  wire logic [1:0]                match_size_one,
  input  wire logic [1:0]                match_size_two,
  input  wire logic [3:0]                value_byte_enables_one,
  input  wire logic [3:0]                value_byte_enables_two,
  input  wire logic [1:0]                value_match_mode_one,
  input  wire logic [1:0]                value_match_mode_two,
  input  wire logic                      clear_read_hit_one,
  input  wire logic                      clear_write_hit_one,
  input  wire logic                      clear_read_hit_two,
  input  wire logic                      clear_write_hit_two,
  output logic                           read_hit_flag_one,
  output logic                           write_hit_flag_one,
  output logic                           read_hit_flag_two,
  output logic                           write_hit_flag_two,
  output logic                           addr_event,
  output logic                           value_event,
  output logic                           debug_int_request,
  output logic                           second_part_abandon,
  output logic [dw_pkg::ADDR_W-1:0]      debug_return_address
);
  import dw_pkg::*;

  // ************************************************************
  // Per-channel views of the control inputs
  // ************************************************************
  logic [ADDR_W-1:0]  cmp_addr [CHAN_N];
  logic [DATA_W-1:0]  cmp_val  [CHAN_N];
  logic [1:0]         size     [CHAN_N];
  logic [BYTES_N-1:0] be       [CHAN_N];
  logic [1:0]         vmode    [CHAN_N];
  logic [CHAN_N-1:0]  rd_en;
  logic [CHAN_N-1:0]  wr_en;
  logic [CHAN_N-1:0]  rd_clr;
  logic [CHAN_N-1:0]  wr_clr;

  assign cmp_addr[0] = data_addr_compare_one;
  assign cmp_addr[1] = data_addr_compare_two;
  assign cmp_val[0]  = data_value_compare_one;
  assign cmp_val[1]  = data_value_compare_two;
  assign size[0]     = match_size_one;
  assign size[1]     = match_size_two;
  assign be[0]       = value_byte_enables_one;
  assign be[1]       = value_byte_enables_two;
  assign vmode[0]    = value_match_mode_one;
  assign vmode[1]    = value_match_mode_two;
  assign rd_en       = {read_watch_enable_two, read_watch_enable_one};
  assign wr_en       = {write_watch_enable_two, write_watch_enable_one};
  assign rd_clr      = {clear_read_hit_two, clear_read_hit_one};
  assign wr_clr      = {clear_write_hit_two, clear_write_hit_one};

  // ************************************************************
  // Access classification
  // ************************************************************
  dw_cls_t cls;

  always_comb begin
    case (access_op)
      OP_LOAD:   cls = CLS_READ;
      OP_STORE:  cls = CLS_WRITE;
      OP_DCBI:   cls = CLS_WRITE;
      OP_DCBZ:   cls = CLS_WRITE;
      OP_DCBA:   cls = CLS_WRITE;
      // Protection sees these as reads; the watch does not
      OP_DCBF:   cls = CLS_WRITE;
      OP_DCBST:  cls = CLS_WRITE;
      OP_DCBT:   cls = CLS_READ;
      OP_DCBTST: cls = CLS_READ;
      OP_ICBT:   cls = CLS_READ;
      OP_ICBI:   cls = CLS_READ;
      OP_DCCCI:  cls = CLS_NONE;
      OP_ICCCI:  cls = CLS_NONE;
      OP_DCREAD: cls = CLS_NONE;
      OP_ICREAD: cls = CLS_NONE;
      default:   cls = CLS_NONE;
    endcase
  end

  logic is_read;
  logic is_write;

  // One evaluation per presented access
  assign is_read  = access_valid && (cls == CLS_READ);
  assign is_write = access_valid && (cls == CLS_WRITE);

  // ************************************************************
  // Range compare shared by both channels
  // ************************************************************
  logic in_span;
  logic range_hit;

  assign in_span = (access_addr >= data_addr_compare_one) &&
                   (access_addr < data_addr_compare_two);
  // Exclusive mode qualifies everything outside the span
  assign range_hit = range_exclusive_select ? !in_span : in_span;

  // ************************************************************
  // Channel compare
  // ************************************************************
  logic [CHAN_N-1:0] exact_hit;
  logic [CHAN_N-1:0] addr_hit;
  logic [CHAN_N-1:0] val_en;
  logic [CHAN_N-1:0] val_hit;
  logic [CHAN_N-1:0] chan_hit;
  logic [CHAN_N-1:0] rd_set;
  logic [CHAN_N-1:0] wr_set;
  logic [CHAN_N-1:0] rd_addr_ev;
  logic [CHAN_N-1:0] wr_addr_ev;
  logic [CHAN_N-1:0] rd_val_ev;
  logic [CHAN_N-1:0] wr_val_ev;

  genvar c;
  generate
    for (c = 0; c < CHAN_N; c++) begin : g_chan
      dw_addr_match #(
        .AW       (ADDR_W)
      ) u_addr (
        .cmp_addr (cmp_addr[c]),
        .op_addr  (access_addr),
        .size     (size[c]),
        .hit      (exact_hit[c])
      );

      dw_value_match #(
        .NB        (BYTES_N)
      ) u_value (
        .cmp_value (cmp_val[c]),
        .op_value  (access_data),
        .byte_en   (be[c]),
        .mode      (vmode[c]),
        .enabled   (val_en[c]),
        .hit       (val_hit[c])
      );

      // Range mode turns exact compare off for both registers
      assign addr_hit[c] = range_compare_enable ? range_hit
                                                : exact_hit[c];
      // Address match only qualifies the value check when enabled
      assign chan_hit[c] = val_en[c] ? (addr_hit[c] && val_hit[c])
                                     : addr_hit[c];

      assign rd_set[c] = is_read && rd_en[c] && chan_hit[c];
      assign wr_set[c] = is_write && wr_en[c] && chan_hit[c];

      assign rd_addr_ev[c] = rd_set[c] && !val_en[c];
      assign wr_addr_ev[c] = wr_set[c] && !val_en[c];
      assign rd_val_ev[c]  = rd_set[c] && val_en[c];
      assign wr_val_ev[c]  = wr_set[c] && val_en[c];
    end
  endgenerate

  logic any_addr_ev;
  logic any_val_ev;

  assign any_addr_ev = (rd_addr_ev | wr_addr_ev) != '0;
  assign any_val_ev  = (rd_val_ev | wr_val_ev) != '0;

  // ************************************************************
  // Sticky status flags
  // ************************************************************
  logic [CHAN_N-1:0] rd_flag_reg;
  logic [CHAN_N-1:0] wr_flag_reg;

  // A hit in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_flag_reg <= {CHAN_N{FLAG_RST}};
      wr_flag_reg <= {CHAN_N{FLAG_RST}};
    end else begin
      rd_flag_reg <= (rd_flag_reg & ~rd_clr) | rd_set;
      wr_flag_reg <= (wr_flag_reg & ~wr_clr) | wr_set;
    end
  end

  assign read_hit_flag_one  = rd_flag_reg[0];
  assign read_hit_flag_two  = rd_flag_reg[1];
  assign write_hit_flag_one = wr_flag_reg[0];
  assign write_hit_flag_two = wr_flag_reg[1];

  // ************************************************************
  // Event pulses and interrupt request
  // ************************************************************
  logic addr_ev_reg;
  logic val_ev_reg;
  logic int_req_reg;
  logic abandon_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_ev_reg <= 1'b0;
      val_ev_reg  <= 1'b0;
    end else begin
      addr_ev_reg <= any_addr_ev;
      val_ev_reg  <= any_val_ev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_req_reg <= 1'b0;
    end else begin
      int_req_reg <= debug_int_enable && (any_addr_ev || any_val_ev);
    end
  end

  // First part already recorded in the flags; the second is dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      abandon_reg <= 1'b0;
    end else begin
      abandon_reg <= debug_int_enable && any_val_ev &&
                     access_first_part;
    end
  end

  assign addr_event          = addr_ev_reg;
  assign value_event         = val_ev_reg;
  assign debug_int_request   = int_req_reg;
  assign second_part_abandon = abandon_reg;

  // ************************************************************
  // Return address capture
  // ************************************************************
  logic [ADDR_W-1:0] ret_addr_reg;

  // Value events fire after completion, so resume past the access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ret_addr_reg <= RA_RST;
    end else if (debug_int_enable && any_val_ev) begin
      ret_addr_reg <= access_next_addr;
    end else if (debug_int_enable && any_addr_ev) begin
      ret_addr_reg <= access_instr_addr;
    end
  end

  assign debug_return_address = ret_addr_reg;
endmodule

// *** logic/dw_pkg.sv ***
// Shared constants and types for the data watchpoint block.
package dw_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int BYTES_N = 4;
  localparam int CHAN_N  = 2;

  // ************************************************************
  // Exact-match size codes
  // ************************************************************
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_HALF  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_LINE  = 2'h3;
  localparam int         LINE_LSB_N = 5;

  // ************************************************************
  // Value compare modes
  // ************************************************************
  localparam logic [1:0] VMODE_UNDEF  = 2'h0;
  localparam logic [1:0] VMODE_AND    = 2'h1;
  localparam logic [1:0] VMODE_OR     = 2'h2;
  localparam logic [1:0] VMODE_AND_OR = 2'h3;
  localparam logic [3:0] BE_NONE      = 4'h0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic             FLAG_RST = 1'b0;
  localparam logic [ADDR_W-1:0] RA_RST  = 32'h00000000;

  // ************************************************************
  // Access operations presented by the load/store pipeline
  // ************************************************************
  typedef enum logic [3:0] {
    OP_LOAD   = 4'h0,
    OP_STORE  = 4'h1,
    OP_DCBA   = 4'h2,
    OP_DCBF   = 4'h3,
    OP_DCBI   = 4'h4,
    OP_DCBST  = 4'h5,
    OP_DCBT   = 4'h6,
    OP_DCBTST = 4'h7,
    OP_DCBZ   = 4'h8,
    OP_DCCCI  = 4'h9,
    OP_DCREAD = 4'hA,
    OP_ICBI   = 4'hB,
    OP_ICBT   = 4'hC,
    OP_ICCCI  = 4'hD,
    OP_ICREAD = 4'hE
  } dw_op_t;

  // Debug class of an access
  typedef enum logic [2:0] {
    CLS_NONE  = 3'h1,
    CLS_READ  = 3'h2,
    CLS_WRITE = 3'h4
  } dw_cls_t;

endpackage

// *** logic/dw_addr_match.sv ***
// Exact-address compare of one channel with size masking.
module dw_addr_match
  import dw_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] cmp_addr,
  input  wire logic [AW-1:0] op_addr,
  input  wire logic [1:0]    size,
  output logic               hit
);
  import dw_pkg::*;

  logic [AW-1:0] mask;

  // Bit 31 in the big-endian numbering is our bit 0
  always_comb begin
    case (size)
      SIZE_BYTE: mask = '1;
      SIZE_HALF: mask = {{(AW-1){1'b1}}, 1'b0};
      SIZE_WORD: mask = {{(AW-2){1'b1}}, 2'b00};
      SIZE_LINE: mask = {{(AW-LINE_LSB_N){1'b1}}, {LINE_LSB_N{1'b0}}};
      default:   mask = '1;
    endcase
  end

  assign hit = ((cmp_addr ^ op_addr) & mask) == '0;
endmodule

// *** logic/dw_value_match.sv ***
// Byte-enabled data value compare of one channel.
module dw_value_match
  import dw_pkg::*;
#(
  parameter int NB = 4
) (
  input  wire logic [8*NB-1:0] cmp_value,
  input  wire logic [8*NB-1:0] op_value,
  input  wire logic [NB-1:0]   byte_en,
  input  wire logic [1:0]      mode,
  output logic                 enabled,
  output logic                 hit
);
  import dw_pkg::*;

  logic [NB-1:0] byte_eq;
  logic [NB-1:0] sel_eq;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_byte
      assign byte_eq[b] = cmp_value[8*b +: 8] == op_value[8*b +: 8];
      assign sel_eq[b]  = byte_en[b] & byte_eq[b];
    end
  endgenerate

  assign enabled = byte_en != '0;

  always_comb begin
    case (mode)
      VMODE_AND:    hit = enabled && ((sel_eq | ~byte_en) == '1);
      VMODE_OR:     hit = sel_eq != '0;
      VMODE_AND_OR: hit = (sel_eq[0] & sel_eq[1]) |
                          (sel_eq[2] & sel_eq[3]);
      // Undefined mode: never matches
      default:      hit = 1'b0;
    endcase
  end
endmodule

// *** test/dw_wp_asserts.sv ***
// Concurrent checks on the watchpoint top-level ports.
module dw_wp_asserts
  import dw_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire logic                      access_valid,
  input wire dw_pkg::dw_op_t            access_op,
  input wire logic [dw_pkg::ADDR_W-1:0] access_addr,
  input wire logic                      access_first_part,
  input wire logic [dw_pkg::ADDR_W-1:0] access_next_addr,
  input wire logic                      debug_int_enable,
  input wire logic [dw_pkg::ADDR_W-1:0] data_addr_compare_one,
  input wire logic [dw_pkg::ADDR_W-1:0] data_addr_compare_two,
  input wire logic                      range_compare_enable,
  input wire logic                      range_exclusive_select,
  input wire logic                      read_watch_enable_one,
  input wire logic                      write_watch_enable_one,
  input wire logic [3:0]                value_byte_enables_one,
  input wire logic [3:0]                value_byte_enables_two,
  input wire logic                      clear_read_hit_one,
  input wire logic                      read_hit_flag_one,
  input wire logic                      write_hit_flag_one,
  input wire logic                      write_hit_flag_two,
  input wire logic                      addr_event,
  input wire logic                      value_event,
  input wire logic                      debug_int_request,
  input wire logic                      second_part_abandon,
  input wire logic [dw_pkg::ADDR_W-1:0] debug_return_address
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rd_op = access_op inside {OP_LOAD, OP_DCBT, OP_DCBTST, OP_ICBT,
                                 OP_ICBI};
  wire wr_op = access_op inside {OP_STORE, OP_DCBA, OP_DCBI, OP_DCBZ,
                                 OP_DCBF, OP_DCBST};
  wire in_rng = access_addr >= data_addr_compare_one &&
                access_addr < data_addr_compare_two;
  wire vo1 = value_byte_enables_one == BE_NONE;

  AST_RANGE_IN: assert property (
    access_valid && access_op == OP_LOAD && range_compare_enable &&
    !range_exclusive_select && read_watch_enable_one && vo1 && in_rng
    |=> read_hit_flag_one && addr_event)
    else $error("inclusive range load missed");
  AST_RANGE_OUT: assert property (
    access_valid && wr_op && range_compare_enable && range_exclusive_select
    && write_watch_enable_one && vo1 && !in_rng |=> write_hit_flag_one)
    else $error("exclusive range store missed");
  AST_STICKY: assert property (
    read_hit_flag_one && !clear_read_hit_one |=> read_hit_flag_one)
    else $error("read flag dropped without clear");
  AST_NO_CLASS: assert property (
    access_valid && !rd_op && !wr_op |=> !addr_event && !value_event)
    else $error("event from non-address cache op");
  AST_RD_ONLY: assert property (
    access_valid && rd_op
    |=> !$rose(write_hit_flag_one) && !$rose(write_hit_flag_two))
    else $error("write flag set by read-class op");
  AST_WR_ONLY: assert property (
    access_valid && wr_op |=> !$rose(read_hit_flag_one))
    else $error("read flag set by write-class op");
  AST_VAL_OFF: assert property (
    access_valid && vo1 && value_byte_enables_two == BE_NONE
    |=> !value_event)
    else $error("value event with value compare off");
  AST_VAL_ON: assert property (
    access_valid && !vo1 && value_byte_enables_two != BE_NONE
    |=> !addr_event)
    else $error("address event with value compare on");
  AST_RET_NEXT: assert property (
    access_valid && debug_int_enable ##1 value_event
    |-> debug_return_address == $past(access_next_addr))
    else $error("value event return address wrong");
  AST_ABANDON: assert property (
    access_valid && access_first_part && debug_int_enable ##1 value_event
    |-> second_part_abandon)
    else $error("first part value event did not abandon");

  cover property (value_event);
  cover property (addr_event && debug_int_request);
  cover property (second_part_abandon);
endmodule

bind dw_watchpoint dw_wp_asserts dw_wp_asserts_inst (
  .clk, .resetn, .access_valid, .access_op, .access_addr,
  .access_first_part, .access_next_addr, .debug_int_enable,
  .data_addr_compare_one, .data_addr_compare_two, .range_compare_enable,
  .range_exclusive_select, .read_watch_enable_one, .write_watch_enable_one,
  .value_byte_enables_one, .value_byte_enables_two, .clear_read_hit_one,
  .read_hit_flag_one, .write_hit_flag_one, .write_hit_flag_two,
  .addr_event, .value_event, .debug_int_request, .second_part_abandon,
  .debug_return_address
);

// *** test/dw_pipe_model.sv ***
// Load/store pipeline model presenting accesses to the watchpoint.
module dw_pipe_model
  import dw_pkg::*;
(
  output logic           access_valid,
  output dw_pkg::dw_op_t access_op,
  output logic [31:0]    access_addr,
  output logic [31:0]    access_data,
  output logic           access_first_part,
  output logic [31:0]    access_instr_addr,
  output logic [31:0]    access_next_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    access_valid = 1'b0;
    access_op = OP_LOAD;
    access_addr = 32'h0;
    access_data = 32'h0;
    access_first_part = 1'b0;
    access_instr_addr = 32'h0;
    access_next_addr = 32'h4;
  end
  // Idle cycles flip the bus so stale values never look valid
  task automatic put(input logic v, input dw_op_t op,
                     input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] ia, input logic f);
    access_valid = v;
    access_op = op;
    access_addr = v ? a : ~access_addr;
    access_data = v ? d : ~access_data;
    access_first_part = v ? f : ~access_first_part;
    access_instr_addr = v ? ia : ~access_instr_addr;
    access_next_addr = v ? ia + 32'h4 : ~access_next_addr;
  endtask
endmodule

// *** test/dw_watchpoint_bench.sv ***
// Self-checking bench for the data watchpoint.
module dw_watchpoint_bench
  import dw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk = 1'b0, resetn = 1'b0, rng = 1'b0, rx = 1'b0, ie = 1'b0;
  logic [31:0] c1 = 32'h0, c2 = 32'h0, v1 = 32'h0, v2 = 32'h0, r, xra;
  logic [1:0] rde = 2'h0, wre = 2'h0, sz1 = 2'h0, sz2 = 2'h0;
  logic [1:0] md1 = 2'h1, md2 = 2'h1;
  logic [3:0] be1 = 4'h0, be2 = 4'h0, clr = 4'h0, xfl;
  logic xae, xve, xir, xab, av, fp;
  logic [31:0] aa, ad, ai, an, ra;
  dw_op_t ao;
  wire [3:0] fl;
  wire ae, ve, ir, ab;
  int miscompares = 0, checks = 0, seed = 18323;
  logic [31:0] rb[4] = '{32'h0FFF, 32'h1000, 32'h1FFF, 32'h2000};
  logic [31:0] xm[6] = '{32'h0, 32'h1, 32'h3, 32'h4, 32'h1F, 32'h20};
  logic [3:0] bt[4] = '{4'h7, 4'h8, 4'hC, 4'hF};
  always #20 clk = ~clk;
  dw_pipe_model dw_pipe_model_inst (.access_valid(av), .access_op(ao),
    .access_addr(aa), .access_data(ad), .access_first_part(fp),
    .access_instr_addr(ai), .access_next_addr(an));
  dw_watchpoint dw_watchpoint_inst (.clk(clk), .resetn(resetn),
    .access_valid(av), .access_op(ao), .access_addr(aa),
    .access_data(ad), .access_first_part(fp), .access_instr_addr(ai),
    .access_next_addr(an), .debug_int_enable(ie),
    .data_addr_compare_one(c1), .data_addr_compare_two(c2),
    .data_value_compare_one(v1), .data_value_compare_two(v2),
    .range_compare_enable(rng), .range_exclusive_select(rx),
    .read_watch_enable_one(rde[0]), .write_watch_enable_one(wre[0]),
    .read_watch_enable_two(rde[1]), .write_watch_enable_two(wre[1]),
    .match_size_one(sz1), .match_size_two(sz2),
    .value_byte_enables_one(be1), .value_byte_enables_two(be2),
    .value_match_mode_one(md1), .value_match_mode_two(md2),
    .clear_read_hit_one(clr[0]), .clear_write_hit_one(clr[1]),
    .clear_read_hit_two(clr[2]), .clear_write_hit_two(clr[3]),
    .read_hit_flag_one(fl[0]), .write_hit_flag_one(fl[1]),
    .read_hit_flag_two(fl[2]), .write_hit_flag_two(fl[3]),
    .addr_event(ae), .value_event(ve), .debug_int_request(ir),
    .second_part_abandon(ab), .debug_return_address(ra));
  // ************************************************************
  // Expectation and checking
  // ************************************************************
  function automatic logic [1:0] cls(input dw_op_t op);
    case (op)
      OP_LOAD, OP_DCBT, OP_DCBTST, OP_ICBT, OP_ICBI: return 2'h1;
      OP_STORE, OP_DCBA, OP_DCBI, OP_DCBZ: return 2'h2;
      OP_DCBF, OP_DCBST: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction
  function automatic logic ahit(input logic [31:0] c, input logic [1:0] s,
                                input logic [31:0] a);
    logic [31:0] m;
    m = s == 2'h3 ? 32'hFFFF_FFE0 : ~((32'h1 << s) - 32'h1);
    if (rng) return (a >= c1 && a < c2) ^ rx;
    return ((a ^ c) & m) == 32'h0;
  endfunction
  function automatic logic vhit(input logic [31:0] c, input logic [31:0] d,
                                input logic [3:0] be, input logic [1:0] md);
    logic [3:0] eq;
    for (int i = 0; i < 4; i++) eq[i] = be[i] && c[8*i+:8] == d[8*i+:8];
    case (md)
      VMODE_AND: return eq == be;
      VMODE_OR: return |eq;
      VMODE_AND_OR: return eq[0] && eq[1] || eq[2] && eq[3];
      default: return 1'b0;
    endcase
  endfunction
  task automatic predict(input logic v, input dw_op_t op,
    input logic [31:0] a, input logic [31:0] d, input logic f,
    input logic [31:0] ia);
    logic [1:0] k;
    logic en;
    logic ev;
    k = cls(op) & {v, v};
    xae = 1'b0;
    xve = 1'b0;
    xfl = xfl & ~clr;
    for (int ch = 0; ch < 2; ch++) begin
      en = (ch ? be2 : be1) != BE_NONE;
      ev = ahit(ch ? c2 : c1, ch ? sz2 : sz1, a) && (!en ||
        vhit(ch ? v2 : v1, d, ch ? be2 : be1, ch ? md2 : md1));
      if (ev && (k[0] && rde[ch] || k[1] && wre[ch])) begin
        xfl[2*ch] = xfl[2*ch] | (k[0] && rde[ch]);
        xfl[2*ch+1] = xfl[2*ch+1] | (k[1] && wre[ch]);
        if (en) xve = 1'b1;
        else xae = 1'b1;
      end
    end
    xir = (xae || xve) && ie;
    xab = xve && f && ie;
    if (xir) xra = xve ? ia + 32'h4 : ia;
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chkw(input string n, input logic [31:0] e,
                      input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // Entered and left at a falling edge, so accesses run back to back
  task automatic access(input logic v, input dw_op_t op,
    input logic [31:0] a, input logic [31:0] d, input logic f,
    input logic [3:0] c);
    logic [31:0] ia;
    ia = $random(seed);
    clr = c;
    dw_pipe_model_inst.put(v, op, a, d, ia, f);
    predict(v, op, a, d, f, ia);
    @(posedge clk);
    #1;
    chkw("flags", {28'h0, xfl}, {28'h0, fl});
    chk1("addr_event", xae, ae);
    chk1("value_event", xve, ve);
    chk1("int_request", xir, ir);
    chk1("abandon", xab, ab);
    chkw("return_addr", xra, ra);
    @(negedge clk);
  endtask
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    #400000;
    miscompares++;
    complete_run;
  end
  initial begin
    xfl = 4'h0;
    xra = RA_RST;
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    chkw("reset flags", 32'h0, {28'h0, fl});
    c1 = 32'h4000;
    c2 = 32'h4000;
    rde = 2'h3;
    wre = 2'h3;
    for (int i = 0; i < 15; i++) begin
      access(1'b0, OP_LOAD, 32'h0, 32'h0, 1'b0, 4'hF);
      access(1'b1, dw_op_t'(i), c1, 32'h0, 1'b0, 4'h0);
    end
    rng = 1'b1;
    c1 = 32'h1000;
    c2 = 32'h2000;
    for (int x = 0; x < 8; x++) begin
      rx = x[2];
      access(1'b0, OP_LOAD, 32'h0, 32'h0, 1'b0, 4'hF);
      access(1'b1, OP_LOAD, rb[x%4], 32'h0, 1'b0, 4'h0);
      access(1'b1, OP_DCBZ, rb[x%4], 32'h0, 1'b0, 4'h0);
    end
    rng = 1'b0;
    c1 = 32'h2042;
    c2 = 32'h8000_0000;
    rde = 2'h1;
    wre = 2'h1;
    for (int j = 0; j < 24; j++) begin
      sz1 = 2'(j / 6);
      access(1'b0, OP_LOAD, 32'h0, 32'h0, 1'b0, 4'hF);
      access(1'b1, OP_LOAD, c1 ^ xm[j%6], 32'h0, 1'b0, 4'h0);
    end
    sz1 = SIZE_BYTE;
    v1 = 32'hABCD_0123;
    for (int j = 0; j < 12; j++) begin
      be1 = bt[j/3];
      md1 = 2'(j % 3 + 1);
      access(1'b0, OP_LOAD, 32'h0, 32'h0, 1'b0, 4'hF);
      access(1'b1, OP_STORE, c1, 32'hABCD_FFFF, 1'b0, 4'h0);
      access(1'b1, OP_STORE, c1 + 32'h1, v1, 1'b0, 4'h0);
    end
    ie = 1'b1;
    be1 = 4'hF;
    md1 = VMODE_AND;
    access(1'b1, OP_STORE, c1, v1, 1'b1, 4'hF);
    access(1'b1, OP_STORE, c1 + 32'h4, 32'h0, 1'b0, 4'h0);
    be1 = BE_NONE;
    access(1'b1, OP_LOAD, c1, 32'h0, 1'b0, 4'h0);
    for (int n = 0; n < 3000; n++) begin
      if (n % 16 == 0) begin
        r = $random(seed);
        {rng, rx, ie, rde, wre, sz1, sz2, be1, be2} = r[18:0];
        md1 = r[20:19] == 2'h0 ? VMODE_AND : r[20:19];
        md2 = r[22:21] == 2'h0 ? VMODE_OR : r[22:21];
        c1 = {20'h0, r[31:24], 4'h0};
        c2 = c1 + {22'h0, r[31:22]};
        v1 = $random(seed);
        v2 = $random(seed);
      end
      r = $random(seed);
      access(r[1:0] != 2'h0, dw_op_t'(r[7:4] % 15),
        r[8] ? c1 ^ {26'h0, r[15:10]} : c2 + {29'h0, r[18:16]} - 32'h4,
        r[9] ? v1 : {v2[31:16], r[31:16]}, r[19],
        r[22:20] == 3'h0 ? r[26:23] : 4'h0);
    end
    complete_run;
  end
endmodule
